// *** verilog/report_ctl_pkg.sv ***
// Purpose: shared constants for the serial reading report control block
// Assumes: 25 MHz clock, 7-bit serial characters
// Notes: offsets are byte addresses on the plain register port
package report_ctl_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_SERIAL = 8'h04;
  localparam logic [7:0] ADDR_NODE = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // format bit positions
  localparam int FMT_CHECKSUM = 0;
  localparam int FMT_LINEFEED = 1;
  localparam int FMT_ECHO = 2;
  localparam int FMT_MULTIPOINT = 3;
  localparam int FMT_ON_COMMAND = 4;
  localparam int FMT_CHAR_HANDSHAKE = 5;
  localparam int FMT_RS485_FITTED = 6;
  localparam int FMT_PRINT_ENABLE = 7;
  // reset values
  localparam logic [7:0] FORMAT_RESET = 8'h94;
  localparam logic [1:0] PARITY_RESET = 2'h0;
  localparam logic STOP_RESET = 1'b1;
  localparam logic [7:0] NODE_RESET = 8'h01;
  localparam logic [15:0] COUNT_RESET = 16'h0001;
  // limits
  localparam logic [7:0] NODE_MAX = 8'hC7;
  localparam logic [15:0] COUNT_MAX = 16'hEA5F;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ILLEGAL = 2'h3;
  // characters
  localparam logic [6:0] CHAR_CR = 7'h0D;
  localparam logic [6:0] CHAR_LF = 7'h0A;
  localparam logic [6:0] CHAR_SEND_CMD = 7'h50;
  // frame positions
  localparam int READING_CHARS = 6;
  localparam logic [3:0] IDX_CHECKSUM = 4'h6;
  localparam logic [3:0] IDX_CR = 4'h7;
  localparam logic [3:0] IDX_LF = 4'h8;
  localparam logic [3:0] IDX_DONE = 4'h9;
  localparam logic [2:0] LAST_FORMAT_BIT = 3'h7;
  localparam logic [2:0] LAST_DIGIT = 3'h4;
  localparam int SYNC_WIDTH = 5;
  typedef enum logic [1:0] {
    MENU_RUN = 2'b00,
    MENU_FORMAT = 2'b01,
    MENU_COUNT = 2'b10
  } menu_e;
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_WAIT = 2'b01,
    FR_SEND = 2'b10
  } frame_e;
endpackage

// *** verilog/pair_buffer.sv ***
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, 7-bit characters
// Notes: full at two entries, in_ready drops so the source stalls
`timescale 1ns/1ps
module pair_buffer
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [6:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [6:0] store [0:1];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] fill;
  logic push;
  logic pop;
  logic next_rd;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_rd = pop ? ~rd_ptr : rd_ptr;

  // storage written at the write index
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      store[0] <= 7'h00;
      store[1] <= 7'h00;
    end
    else if (push)
      store[wr_ptr] <= in_data;
  end

  // pointers and fill level, flags kept as flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= 7'h00;
    end
    else
    begin
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      fill <= fill + {1'b0, push} - {1'b0, pop};
      in_ready <= (fill + {1'b0, push} - {1'b0, pop}) != 2'h2;
      out_valid <= (fill + {1'b0, push} - {1'b0, pop}) != 2'h0;
      // head kept in a flop so the link side sees no mux glitch
      out_data <= (push && wr_ptr == next_rd) ? in_data : store[next_rd];
    end
  end
endmodule // pair_buffer

// *** verilog/serial_reading_report_control.sv ***
// Purpose: report format settings, panel setup and reading framer for the serial link
// Assumes: 25 MHz clk, buttons and pins asynchronous, rx and readings on clk
// Notes on behaviour
// - checksum character appended when format bit set, omitted otherwise, default off
// - line feed sent after each carriage return when set, default off
// - received characters echoed when echo bit set, default on
// - topology bit: point-to-point at 0, multipoint at 1, default 0
// - point-to-point only: continuous at 0, on host command at 1, default 1
// - continuous mode handshake per whole message at 0 or per character at 1
// - board-present bit shows RS-485 board fitted, default not fitted
// - print-request pin starts a report only when print enable set, default on
// - reading count held from 1 to 59999, default 1
// - format setup: one button steps bit, other toggles, menu commits and advances
// - count setup: one button moves digit, other increments digit
// - menu commits count, ends setup, returns to run mode
// - characters always seven data bits
// - parity none/odd/even, stop one/two; none with one stop refused
// - bus address held from 0 to 199, default 1
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module serial_reading_report_control
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic btn_menu_n,
  input wire logic btn_step_n,
  input wire logic btn_change_n,
  input wire logic print_req_n,
  input wire logic host_cts,
  input wire logic reading_done,
  input wire logic [41:0] reading_text,
  input wire logic [6:0] rx_char,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [6:0] tx_char,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] report_format,
  output logic [1:0] parity_sel,
  output logic stop_bits_sel,
  output logic [7:0] bus_node_address,
  output logic [15:0] readings_per_report,
  output logic rs485_fitted,
  output logic in_setup
);
  // pin synchronisers: menu, step, change, print, cts
  logic [report_ctl_pkg::SYNC_WIDTH-1:0] pin_raw;
  logic [report_ctl_pkg::SYNC_WIDTH-1:0] sync_a;
  logic [report_ctl_pkg::SYNC_WIDTH-1:0] sync_b;
  logic [report_ctl_pkg::SYNC_WIDTH-1:0] sync_prev;
  logic [report_ctl_pkg::SYNC_WIDTH-1:0] press;
  assign pin_raw = {host_cts, ~print_req_n, ~btn_change_n, ~btn_step_n, ~btn_menu_n};

  genvar g;
  generate
    for (g = 0; g < report_ctl_pkg::SYNC_WIDTH; g++)
    begin : gen_sync
      // two stages before any logic looks at a pin
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          sync_a[g] <= 1'b0;
          sync_b[g] <= 1'b0;
          sync_prev[g] <= 1'b0;
        end
        else
        begin
          sync_a[g] <= pin_raw[g];
          sync_b[g] <= sync_a[g];
          sync_prev[g] <= sync_b[g];
        end
      end
      assign press[g] = sync_b[g] && !sync_prev[g];
    end
  endgenerate

  logic menu_press;
  logic step_press;
  logic change_press;
  logic print_press;
  logic cts_ok;
  assign menu_press = press[0];
  assign step_press = press[1];
  assign change_press = press[2];
  assign print_press = press[3];
  assign cts_ok = sync_b[4];

  // panel setup state
  report_ctl_pkg::menu_e menu_state;
  logic [7:0] format_work;
  logic [2:0] sel_bit;
  logic [3:0] digit [0:4];
  logic [2:0] sel_digit;
  logic [16:0] entered_count;
  assign entered_count = 17'(digit[0]) * 17'd10000 + 17'(digit[1]) * 17'd1000 + 17'(digit[2]) * 17'd100
    + 17'(digit[3]) * 17'd10 + 17'(digit[4]);

  // panel walk: run -> format -> count -> run
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      menu_state <= report_ctl_pkg::MENU_RUN;
      format_work <= report_ctl_pkg::FORMAT_RESET;
      sel_bit <= 3'h0;
      sel_digit <= 3'h0;
      for (int i = 0; i < 5; i++)
        digit[i] <= 4'h0;
    end
    else
    begin
      unique case (menu_state)
        report_ctl_pkg::MENU_RUN:
        begin
          if (menu_press)
          begin
            menu_state <= report_ctl_pkg::MENU_FORMAT;
            format_work <= report_format;
            sel_bit <= 3'h0;
          end
        end
        report_ctl_pkg::MENU_FORMAT:
        begin
          if (menu_press)
          begin
            menu_state <= report_ctl_pkg::MENU_COUNT;
            sel_digit <= 3'h0;
            digit[0] <= 4'(readings_per_report / 16'd10000);
            digit[1] <= 4'((readings_per_report / 16'd1000) % 16'd10);
            digit[2] <= 4'((readings_per_report / 16'd100) % 16'd10);
            digit[3] <= 4'((readings_per_report / 16'd10) % 16'd10);
            digit[4] <= 4'(readings_per_report % 16'd10);
          end
          else if (step_press)
            sel_bit <= (sel_bit == report_ctl_pkg::LAST_FORMAT_BIT) ? 3'h0 : sel_bit + 3'h1;
          else if (change_press)
            format_work[sel_bit] <= ~format_work[sel_bit];
        end
        report_ctl_pkg::MENU_COUNT:
        begin
          if (menu_press)
            menu_state <= report_ctl_pkg::MENU_RUN;
          else if (step_press)
            sel_digit <= (sel_digit == report_ctl_pkg::LAST_DIGIT) ? 3'h0 : sel_digit + 3'h1;
          else if (change_press)
            digit[sel_digit] <= (digit[sel_digit] == 4'h9 || (sel_digit == 3'h0 && digit[0] == 4'h5))
              ? 4'h0 : digit[sel_digit] + 4'h1;
        end
        default:
          menu_state <= report_ctl_pkg::MENU_RUN;
      endcase
    end
  end

  // settings: format and count from the panel commits or the register port, serial and node from the port only
  logic wr_format;
  logic wr_serial;
  logic wr_node;
  logic wr_count;
  assign wr_format = reg_wr && reg_addr == report_ctl_pkg::ADDR_FORMAT;
  assign wr_serial = reg_wr && reg_addr == report_ctl_pkg::ADDR_SERIAL;
  assign wr_node = reg_wr && reg_addr == report_ctl_pkg::ADDR_NODE;
  assign wr_count = reg_wr && reg_addr == report_ctl_pkg::ADDR_COUNT;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      report_format <= report_ctl_pkg::FORMAT_RESET;
      parity_sel <= report_ctl_pkg::PARITY_RESET;
      stop_bits_sel <= report_ctl_pkg::STOP_RESET;
      bus_node_address <= report_ctl_pkg::NODE_RESET;
      readings_per_report <= report_ctl_pkg::COUNT_RESET;
    end
    else
    begin
      if (menu_state == report_ctl_pkg::MENU_FORMAT && menu_press)
        report_format <= format_work;
      else if (wr_format)
        report_format <= reg_wdata[7:0];
      // a zero or out-of-range count is refused, old value kept
      if (menu_state == report_ctl_pkg::MENU_COUNT && menu_press)
      begin
        if (entered_count != 17'h0 && entered_count <= {1'b0, report_ctl_pkg::COUNT_MAX})
          readings_per_report <= entered_count[15:0];
      end
      else if (wr_count && reg_wdata != 16'h0 && reg_wdata <= report_ctl_pkg::COUNT_MAX)
        readings_per_report <= reg_wdata;
      // no parity with one stop bit cannot be framed, so refuse it
      if (wr_serial && reg_wdata[1:0] != report_ctl_pkg::PARITY_ILLEGAL
          && !(reg_wdata[1:0] == report_ctl_pkg::PARITY_NONE && !reg_wdata[2]))
      begin
        parity_sel <= reg_wdata[1:0];
        stop_bits_sel <= reg_wdata[2];
      end
      if (wr_node && reg_wdata[7:0] <= report_ctl_pkg::NODE_MAX && reg_wdata[15:8] == 8'h00)
        bus_node_address <= reg_wdata[7:0];
    end
  end

  // mode decode
  logic continuous;
  assign continuous = !report_format[report_ctl_pkg::FMT_MULTIPOINT]
    && !report_format[report_ctl_pkg::FMT_ON_COMMAND];

  // reading counter for continuous reporting
  logic [15:0] reading_count;
  logic count_hit;
  assign count_hit = continuous && reading_done && reading_count + 16'h1 >= readings_per_report;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reading_count <= 16'h0;
    else if (!continuous || count_hit)
      reading_count <= 16'h0;
    else if (reading_done)
      reading_count <= reading_count + 16'h1;
  end

  // echo path: one pending character, rx stalls while it waits
  logic [6:0] echo_char;
  logic echo_pend;
  logic rx_take;
  logic cmd_seen;
  logic push_echo;
  assign rx_take = rx_valid && rx_ready;
  assign cmd_seen = rx_take && rx_char == report_ctl_pkg::CHAR_SEND_CMD && !continuous;

  // framer
  report_ctl_pkg::frame_e frame_state;
  logic report_pend;
  logic [41:0] frame_text;
  logic [3:0] char_idx;
  logic [6:0] frame_char;
  logic [6:0] buf_data;
  logic buf_valid;
  logic buf_ready;
  logic push_frame;

  // simple 7-bit sum; swap this function to change the check scheme
  function automatic logic [6:0] check_of(input logic [41:0] text);
    logic [6:0] acc;
    acc = 7'h00;
    for (int i = 0; i < report_ctl_pkg::READING_CHARS; i++)
      acc = acc + text[i*7 +: 7];
    return acc;
  endfunction

  // character at the current frame position, first reading char in the top bits
  always_comb
  begin
    frame_char = report_ctl_pkg::CHAR_CR;
    if (char_idx < report_ctl_pkg::IDX_CHECKSUM)
      frame_char = frame_text[(5 - char_idx) * 7 +: 7];
    else if (char_idx == report_ctl_pkg::IDX_CHECKSUM)
      frame_char = check_of(frame_text);
    else if (char_idx == report_ctl_pkg::IDX_LF)
      frame_char = report_ctl_pkg::CHAR_LF;
  end

  // per-character handshake needs cts before every character
  assign push_frame = frame_state == report_ctl_pkg::FR_SEND && buf_ready
    && (!report_format[report_ctl_pkg::FMT_CHAR_HANDSHAKE] || !continuous || cts_ok);
  assign push_echo = echo_pend && !push_frame && frame_state != report_ctl_pkg::FR_SEND && buf_ready;
  assign buf_data = push_frame ? frame_char : echo_char;
  assign buf_valid = push_frame || push_echo;

  // request flag: a new trigger wins over the clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      report_pend <= 1'b0;
    else if (count_hit || cmd_seen || (print_press && report_format[report_ctl_pkg::FMT_PRINT_ENABLE]))
      report_pend <= 1'b1;
    else if (frame_state == report_ctl_pkg::FR_IDLE)
      report_pend <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      frame_state <= report_ctl_pkg::FR_IDLE;
      frame_text <= 42'h0;
      char_idx <= 4'h0;
    end
    else
    begin
      unique case (frame_state)
        report_ctl_pkg::FR_IDLE:
          if (report_pend)
          begin
            frame_text <= reading_text;
            char_idx <= 4'h0;
            frame_state <= report_ctl_pkg::FR_WAIT;
          end
        report_ctl_pkg::FR_WAIT:
          // message handshake checks cts once for the whole frame
          if (!continuous || report_format[report_ctl_pkg::FMT_CHAR_HANDSHAKE] || cts_ok)
            frame_state <= report_ctl_pkg::FR_SEND;
        report_ctl_pkg::FR_SEND:
          if (push_frame)
          begin
            if (char_idx == report_ctl_pkg::IDX_LF
                || (char_idx == report_ctl_pkg::IDX_CR && !report_format[report_ctl_pkg::FMT_LINEFEED]))
              frame_state <= report_ctl_pkg::FR_IDLE;
            else if (char_idx == 4'h5 && !report_format[report_ctl_pkg::FMT_CHECKSUM])
              char_idx <= report_ctl_pkg::IDX_CR;
            else
              char_idx <= char_idx + 4'h1;
          end
        default:
          frame_state <= report_ctl_pkg::FR_IDLE;
      endcase
    end
  end

  // echo holding register; echo off simply drops the character
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      echo_char <= 7'h00;
      echo_pend <= 1'b0;
    end
    else if (rx_take && report_format[report_ctl_pkg::FMT_ECHO])
    begin
      echo_char <= rx_char;
      echo_pend <= 1'b1;
    end
    else if (push_echo)
      echo_pend <= 1'b0;
  end

  // rx_ready as a flop: low while an echo waits or the next cycle will hold one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_ready <= 1'b1;
    else
      rx_ready <= !((echo_pend && !push_echo) || (rx_take && report_format[report_ctl_pkg::FMT_ECHO]));
  end

  pair_buffer u_tx_buffer
  (
    .clk(clk),
    .rst(rst),
    .in_data(buf_data),
    .in_valid(buf_valid),
    .in_ready(buf_ready),
    .out_data(tx_char),
    .out_valid(tx_valid),
    .out_ready(tx_ready)
  );

  // status flops and registered read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rs485_fitted <= 1'b0;
      in_setup <= 1'b0;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      rs485_fitted <= report_format[report_ctl_pkg::FMT_RS485_FITTED];
      in_setup <= menu_state != report_ctl_pkg::MENU_RUN;
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          report_ctl_pkg::ADDR_FORMAT: reg_rdata <= {8'h00, report_format};
          report_ctl_pkg::ADDR_SERIAL: reg_rdata <= {13'h0000, stop_bits_sel, parity_sel};
          report_ctl_pkg::ADDR_NODE: reg_rdata <= {8'h00, bus_node_address};
          report_ctl_pkg::ADDR_COUNT: reg_rdata <= readings_per_report;
          report_ctl_pkg::ADDR_STATUS: reg_rdata <= {9'h000, sel_digit, frame_state, menu_state};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // serial_reading_report_control

// *** tb/report_ctl_properties.sv ***
// Purpose: port assertions for the report control block
// Assumes: one clock, async active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module report_ctl_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [6:0] tx_char,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] report_format,
  input wire logic [1:0] parity_sel,
  input wire logic stop_bits_sel,
  input wire logic [7:0] bus_node_address,
  input wire logic [15:0] readings_per_report,
  input wire logic rs485_fitted,
  input wire logic in_setup
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // settings never leave their legal ranges, whoever wrote them
  chk_count_range: assert property (readings_per_report != 16'h0000 && readings_per_report <= 16'hEA5F)
    else $error("count setting out of range");
  chk_node_range: assert property (bus_node_address <= 8'hC7)
    else $error("node address out of range");
  chk_serial_legal: assert property (parity_sel != 2'h3 && !(parity_sel == 2'h0 && !stop_bits_sel))
    else $error("illegal serial framing held");
  // board flag follows the format bit one cycle late
  chk_fitted_copy: assert property (rs485_fitted == $past(report_format[6]))
    else $error("board flag does not follow format");
  // a stalled character must not change under the host
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_char))
    else $error("stalled character changed");
  // read data mirrors the live settings
  chk_count_read: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == $past(readings_per_report))
    else $error("count read mismatch");
  chk_serial_read: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata == {13'h0000, $past(stop_bits_sel), $past(parity_sel)})
    else $error("serial read mismatch");
  // an echoed character blocks further input in the cycle after it is taken
  chk_echo_hold: assert property (rx_valid && rx_ready && report_format[2] |=> !rx_ready)
    else $error("input not held during echo");
  cover property (tx_valid && tx_ready && tx_char == 7'h0D);
  cover property ($rose(in_setup));
  cover property (rx_valid && rx_ready);
endmodule // report_ctl_properties

bind serial_reading_report_control report_ctl_properties chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_char(tx_char),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .report_format(report_format), .parity_sel(parity_sel),
  .stop_bits_sel(stop_bits_sel), .bus_node_address(bus_node_address),
  .readings_per_report(readings_per_report), .rs485_fitted(rs485_fitted), .in_setup(in_setup));

// *** tb/host_model.sv ***
// Purpose: host computer on the serial side of the block
// Assumes: characters exchanged on clk with valid/ready
// Notes: idle command line shows the inverse of its last value
`timescale 1ns/1ps
module host_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic send_go,
  input wire logic [6:0] send_char,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [6:0] rx_char,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic host_cts
);
  // one stall source drives both the sink and the permit
  assign tx_ready = !stall;
  assign host_cts = !stall;
  // command source holds a character until taken
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rx_valid <= 1'b0;
      rx_char <= 7'h7F;
    end
    else if (rx_valid && rx_ready)
    begin
      rx_valid <= 1'b0;
      rx_char <= ~rx_char;
    end
    else if (send_go && !rx_valid)
    begin
      rx_valid <= 1'b1;
      rx_char <= send_char;
    end
endmodule // host_model

// *** tb/serial_reading_report_control_tb.sv ***
// Purpose: self-checking bench for the report control block
// Assumes: 25 MHz clock, host model on the serial side
// Notes: expected reads and characters queue up, a monitor pops them
`timescale 1ns/1ps
module serial_reading_report_control_tb;
  // addr, write data, expected read back
  localparam logic [39:0] TBL [8] = '{40'h0C_0000_0001, 40'h0C_EA60_0001, 40'h0C_EA5F_EA5F,
    40'h08_00C8_0001, 40'h08_00C7_00C7, 40'h04_0003_0004, 40'h04_0000_0004, 40'h04_0002_0002};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pins_n = 4'hF;
  logic reading_done = 1'b0;
  logic [41:0] reading_text = '0;
  logic stall = 1'b0;
  logic stall_on = 1'b0;
  logic send_go = 1'b0;
  logic [6:0] send_char = 7'h00;
  logic [15:0] reg_rdata;
  logic host_cts, rx_valid, rx_ready, tx_valid, tx_ready, rs485_fitted, in_setup, rd_seen;
  logic [6:0] rx_char, tx_char;
  logic [31:0] seed = 32'h00016B50;
  logic [15:0] rd_q[$];
  logic [15:0] tx_q[$];
  int bad_count = 0;
  int compares = 0;

  serial_reading_report_control dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .btn_menu_n(pins_n[0]), .btn_step_n(pins_n[1]),
    .btn_change_n(pins_n[2]), .print_req_n(pins_n[3]), .host_cts(host_cts), .reading_done(reading_done),
    .reading_text(reading_text), .rx_char(rx_char), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_char(tx_char), .tx_valid(tx_valid), .tx_ready(tx_ready), .report_format(), .parity_sel(),
    .stop_bits_sel(), .bus_node_address(), .readings_per_report(), .rs485_fitted(rs485_fitted),
    .in_setup(in_setup));
  host_model host_u (.clk(clk), .rst(rst), .stall(stall), .send_go(send_go), .send_char(send_char),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .host_cts(host_cts));

  // clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // random host stalls, so every frame meets back-pressure
  always @(posedge clk)
  begin
    seed = xs(seed);
    stall <= stall_on & seed[0];
  end

  // monitor: read data one cycle after the strobe, characters on transfer
  always @(posedge clk)
  begin
    if (rd_seen === 1'b1)
      check(reg_rdata, rd_q.pop_front());
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      check({9'h000, tx_char}, tx_q.size() != 0 ? tx_q.pop_front() : 16'hFFFF);
    rd_seen = reg_rd;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic press(input int b);
    pins_n[b] <= 1'b0;
    repeat (5) @(posedge clk);
    pins_n[b] <= 1'b1;
    repeat (5) @(posedge clk);
  endtask

  task automatic send(input logic [6:0] c);
    send_char <= c;
    send_go <= 1'b1;
    @(posedge clk);
    send_go <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse_done();
    reading_done <= 1'b1;
    @(posedge clk);
    reading_done <= 1'b0;
    @(posedge clk);
  endtask

  // new reading text and the frame it should produce
  task automatic next_frame(input logic cs, input logic lf);
    logic [41:0] t;
    logic [6:0] sum;
    t = {seed, seed[9:0]};
    sum = 7'h00;
    reading_text <= t;
    for (int i = 5; i >= 0; i--)
    begin
      tx_q.push_back({9'h000, t[i*7 +: 7]});
      sum = sum + t[i*7 +: 7];
    end
    if (cs)
      tx_q.push_back({9'h000, sum});
    tx_q.push_back({9'h000, report_ctl_pkg::CHAR_CR});
    if (lf)
      tx_q.push_back({9'h000, report_ctl_pkg::CHAR_LF});
  endtask

  // bounded wait for all expected characters, then a quiet spell
  task automatic drain();
    int n;
    n = 0;
    while (tx_q.size() != 0 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    if (tx_q.size() != 0)
    begin
      bad_count++;
      $display("[ERR] %0t characters missing", $time);
      tally_and_finish();
    end
    repeat (30) @(posedge clk);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // reset values, an unmapped place, refused and boundary writes
    rd(report_ctl_pkg::ADDR_FORMAT, 16'h0094);
    rd(report_ctl_pkg::ADDR_SERIAL, 16'h0004);
    rd(report_ctl_pkg::ADDR_NODE, 16'h0001);
    rd(report_ctl_pkg::ADDR_COUNT, 16'h0001);
    rd(8'h14, 16'h0000);
    foreach (TBL[i])
    begin
      wr(TBL[i][39:32], TBL[i][31:16]);
      rd(TBL[i][39:32], TBL[i][15:0]);
    end
    stall_on <= 1'b1;
    // print pin with defaults, then with checksum and line feed
    next_frame(1'b0, 1'b0);
    press(3);
    drain();
    wr(report_ctl_pkg::ADDR_FORMAT, 16'h0097);
    next_frame(1'b1, 1'b1);
    press(3);
    drain();
    // print disabled: pin ignored
    wr(report_ctl_pkg::ADDR_FORMAT, 16'h0017);
    press(3);
    drain();
    // echo on gives the character back; echo off with command gives only a frame
    tx_q.push_back(16'h0041);
    send(7'h41);
    drain();
    wr(report_ctl_pkg::ADDR_FORMAT, 16'h0013);
    next_frame(1'b1, 1'b1);
    send(report_ctl_pkg::CHAR_SEND_CMD);
    drain();
    // multipoint is never continuous; board flag follows
    wr(report_ctl_pkg::ADDR_FORMAT, 16'h0048);
    repeat (2) pulse_done();
    drain();
    check({15'h0000, rs485_fitted}, 16'h0001);
    // continuous, message then character handshake, one frame per three readings
    wr(report_ctl_pkg::ADDR_COUNT, 16'h0003);
    for (int m = 0; m < 2; m++)
    begin
      wr(report_ctl_pkg::ADDR_FORMAT, m != 0 ? 16'h0020 : 16'h0000);
      repeat (2) pulse_done();
      drain();
      next_frame(1'b0, 1'b0);
      pulse_done();
      drain();
    end
    // panel: toggle bits 0 and 1, commit, add one thousand to the count
    press(0);
    check({15'h0000, in_setup}, 16'h0001);
    rd(report_ctl_pkg::ADDR_STATUS, 16'h0001);
    press(2);
    press(1);
    press(2);
    press(0);
    press(1);
    press(2);
    press(0);
    check({15'h0000, in_setup}, 16'h0000);
    rd(report_ctl_pkg::ADDR_FORMAT, 16'h0023);
    rd(report_ctl_pkg::ADDR_COUNT, 16'h03EB);
    tally_and_finish();
  end
endmodule // serial_reading_report_control_tb
